// [logic/psf_cfg.svh]
// psf_cfg.svh: bit positions, field codes and limits of the sync command
// assumes: included by the sync checker modules
`ifndef PSF_CFG_SVH
`define PSF_CFG_SVH

// argument bit positions in the second dword
`define PSF_BIT_TILE_FLUSH     28
`define PSF_BIT_REG_LOAD_PS    23
`define PSF_BIT_STORE_INDEX    21
`define PSF_BIT_STALL          20
`define PSF_BIT_SNAP_RESET     19
`define PSF_BIT_XLAT_INV       18
`define PSF_BIT_MEDIA_CLEAR    16
`define PSF_BIT_PS_OP_HI       15
`define PSF_BIT_PS_OP_LO       14
`define PSF_BIT_RT_FLUSH       12
`define PSF_BIT_INST_INV       11
`define PSF_BIT_TEX_INV        10
`define PSF_BIT_ISP_DISABLE    9
`define PSF_BIT_NOTIFY         8
`define PSF_BIT_VF_INV         4
`define PSF_BIT_CONST_INV      3
`define PSF_BIT_STATE_INV      2
`define PSF_BIT_DEPTH_FLUSH    0
`define PSF_BIT_DC_FLUSH       5

// post-sync operation codes
`define PSF_PS_NONE            2'h0
`define PSF_PS_DEPTH_COUNT     2'h2

// outstanding marker limit and tracker width
`define PSF_MAX_OUT            6'h20
`define PSF_CNT_W              6

// interrupt status bit positions
`define PSF_IRQ_INVALID        0
`define PSF_IRQ_DONE           1
`define PSF_IRQ_W              2

`endif

// [logic/psf_checker.sv]
// psf_checker: sync command interpreter for the render streamer
// assumes: one command word offered with cmd_valid, held until cmd_ready
// Behaviour
// - render target, depth or data cache flush, or notify, sends marker with completion
// - top invalidate pulse only on non-vertex invalidate
// - post-sync waits for marker completion
// - in tile mode, flush level-1 caches before tile cache when the tile flush comes with both render target and depth flush
// - unified mode flushes pick their streams
// - stall bit waits for full drain
// - track up to 32 outstanding syncs
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "psf_cfg.svh"
module psf_checker (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire logic [31:0] cmd_dword,
    input  wire logic        pos_only,
    input  wire logic        tile_mode,
    input  wire logic        marker_done,
    input  wire logic        l1_done,
    input  wire logic        tile_done,
    input  wire logic        pipe_idle,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic             cmd_ready,
    output logic             marker_valid,
    output logic             marker_pipe,
    output logic             marker_completion,
    output logic             top_inv_pulse,
    output logic             l1_flush,
    output logic             tile_flush,
    output logic             dc_flush_obs,
    output logic             color_depth_obs,
    output logic             post_sync_go,
    output logic             irq,
    output logic [31:0]      reg_rdata
);
    // register indices
    localparam logic [3:0] A_STATUS = 4'h0;
    localparam logic [3:0] A_MASK   = 4'h1;
    localparam logic [3:0] A_COUNT  = 4'h2;
    localparam logic [3:0] A_STATE  = 4'h3;

    psf_pkg::psf_state_t state;
    psf_pkg::psf_state_t next_state;

    logic                        d_send;
    logic                        d_pipe;
    logic                        d_comp;
    logic                        d_top;
    logic                        d_bad;
    logic                        d_stall;
    logic                        d_seq;
    logic [`PSF_CNT_W-1:0]       count;
    logic                        t_full;
    logic                        t_empty;
    logic [`PSF_IRQ_W-1:0]       status;
    logic [`PSF_IRQ_W-1:0]       mask;
    logic [31:0]                 last_cmd;
    logic                        pend_ps;

    psf_decode u_dec (
        .dword        (cmd_dword),
        .pos_only     (pos_only),
        .tile_mode    (tile_mode),
        .marker_send  (d_send),
        .marker_pipe  (d_pipe),
        .completion   (d_comp),
        .top_inv      (d_top),
        .is_invalid   (d_bad),
        .need_stall   (d_stall),
        .l1_then_tile (d_seq)
    );

    // accept only in idle with tracker room
    wire take     = cmd_valid & cmd_ready;
    wire good     = take & ~d_bad;
    wire launch   = good & d_send;
    wire uni_tile = good & ~tile_mode & cmd_dword[`PSF_BIT_TILE_FLUSH];
    wire uni_dc   = good & ~tile_mode & cmd_dword[`PSF_BIT_DC_FLUSH];
    wire ps_req   = good & d_comp;

    psf_tracker u_trk (
        .clock  (clock),
        .rst_n  (rst_n),
        .launch (launch),
        .done   (marker_done),
        .count  (count),
        .full   (t_full),
        .empty  (t_empty)
    );

    // sequencing of flushes, stalls and the outstanding limit
    always_comb begin
        next_state = state;
        case (state)
            psf_pkg::PSF_IDLE: begin
                if (good & tile_mode & d_seq)
                    next_state = psf_pkg::PSF_L1;
                else if (good & d_stall)
                    next_state = psf_pkg::PSF_DRAIN;
                else if (launch & (count == `PSF_MAX_OUT - `PSF_CNT_W'(1)))
                    next_state = psf_pkg::PSF_FULL;
            end
            psf_pkg::PSF_L1: begin
                if (l1_done)
                    next_state = psf_pkg::PSF_TILE;
            end
            psf_pkg::PSF_TILE: begin
                if (tile_done)
                    next_state = last_cmd[`PSF_BIT_STALL]
                               ? psf_pkg::PSF_DRAIN : psf_pkg::PSF_IDLE;
            end
            psf_pkg::PSF_DRAIN: begin
                if (pipe_idle & t_empty)
                    next_state = psf_pkg::PSF_IDLE;
            end
            psf_pkg::PSF_FULL: begin
                if (~t_full)
                    next_state = psf_pkg::PSF_IDLE;
            end
            default: next_state = psf_pkg::PSF_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            state <= psf_pkg::PSF_IDLE;
        else
            state <= next_state;
    end

    // ready and command capture
    wire next_ready = (next_state == psf_pkg::PSF_IDLE) & ~take;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmd_ready <= 1'b0;
            last_cmd  <= 32'h0000_0000;
        end else begin
            cmd_ready <= next_ready;
            if (take)
                last_cmd <= cmd_dword;
        end
    end

    // marker launch and top of pipe pulse, one cycle each
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            marker_valid      <= 1'b0;
            marker_pipe       <= 1'b0;
            marker_completion <= 1'b0;
            top_inv_pulse     <= 1'b0;
        end else begin
            marker_valid      <= launch;
            marker_pipe       <= launch & d_pipe;
            marker_completion <= launch & d_comp;
            top_inv_pulse     <= good & d_top;
        end
    end

    // cache flush strobes: l1 first, tile after l1 is done when l1_then_tile, else both in the same cycle
    wire next_l1   = (next_state == psf_pkg::PSF_L1)
                   | (good & tile_mode & ~d_seq
                      & (cmd_dword[`PSF_BIT_RT_FLUSH]
                         | cmd_dword[`PSF_BIT_DEPTH_FLUSH]));
    wire next_tile = (next_state == psf_pkg::PSF_TILE)
                   | (good & tile_mode & ~d_seq
                      & cmd_dword[`PSF_BIT_TILE_FLUSH]);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            l1_flush        <= 1'b0;
            tile_flush      <= 1'b0;
            dc_flush_obs    <= 1'b0;
            color_depth_obs <= 1'b0;
        end else begin
            l1_flush        <= next_l1;
            tile_flush      <= next_tile;
            dc_flush_obs    <= uni_dc;
            color_depth_obs <= uni_tile;
        end
    end

    // post-sync held until the marker completes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pend_ps      <= 1'b0;
            post_sync_go <= 1'b0;
        end else begin
            pend_ps      <= (pend_ps | ps_req) & ~marker_done;
            post_sync_go <= marker_done & (pend_ps | ps_req);
        end
    end

    // sticky status, write one to clear, set wins
    wire                  st_wr   = reg_wr & (reg_addr == A_STATUS);
    wire [`PSF_IRQ_W-1:0] st_set  = {marker_done, take & d_bad};
    wire [`PSF_IRQ_W-1:0] st_clr  = st_wr ? reg_wdata[`PSF_IRQ_W-1:0]
                                          : {`PSF_IRQ_W{1'b0}};
    wire [`PSF_IRQ_W-1:0] next_st = (status & ~st_clr) | st_set;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status <= '0;
            mask   <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_st;
            if (reg_wr & (reg_addr == A_MASK))
                mask <= reg_wdata[`PSF_IRQ_W-1:0];
            irq <= |(next_st & mask);
        end
    end

    // read mux, unmapped reads zero
    wire [31:0] rd_mux =
        (reg_addr == A_STATUS) ? {30'h0, status} :
        (reg_addr == A_MASK)   ? {30'h0, mask}   :
        (reg_addr == A_COUNT)  ? {26'h0, count}  :
        (reg_addr == A_STATE)  ? {27'h0, state}  : 32'h0000_0000;

    always_ff @(posedge clock) begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
endmodule

// [logic/psf_decode.sv]
// psf_decode: pure decode of a sync command second dword
// assumes: dword is steady while cmd_valid is high in the parent
`timescale 1ns/1ps
`include "psf_cfg.svh"
module psf_decode (
    input  wire logic [31:0] dword,
    input  wire logic        pos_only,
    input  wire logic        tile_mode,
    output logic             marker_send,
    output logic             marker_pipe,
    output logic             completion,
    output logic             top_inv,
    output logic             is_invalid,
    output logic             need_stall,
    output logic             l1_then_tile
);
    wire       wr_flush = dword[`PSF_BIT_RT_FLUSH] | dword[`PSF_BIT_DEPTH_FLUSH]
                        | dword[`PSF_BIT_DC_FLUSH];
    wire       notify   = dword[`PSF_BIT_NOTIFY];
    wire       ro_inv   = dword[`PSF_BIT_INST_INV] | dword[`PSF_BIT_TEX_INV]
                        | dword[`PSF_BIT_CONST_INV] | dword[`PSF_BIT_STATE_INV];
    wire       vf_inv   = dword[`PSF_BIT_VF_INV];
    wire [1:0] ps_op    = dword[`PSF_BIT_PS_OP_HI:`PSF_BIT_PS_OP_LO];
    wire       stall    = dword[`PSF_BIT_STALL];
    wire       stall_req = dword[`PSF_BIT_SNAP_RESET]
                         | dword[`PSF_BIT_MEDIA_CLEAR]
                         | dword[`PSF_BIT_ISP_DISABLE]
                         | dword[`PSF_BIT_XLAT_INV];
    wire       bad_rl   = dword[`PSF_BIT_REG_LOAD_PS] & (ps_op != `PSF_PS_NONE);
    wire       bad_sdi  = dword[`PSF_BIT_STORE_INDEX] & (ps_op == `PSF_PS_NONE);
    wire       bad_pos  = pos_only & (dword[`PSF_BIT_MEDIA_CLEAR] | notify
                        | (ps_op == `PSF_PS_DEPTH_COUNT));
    wire       bad_tile = tile_mode & dword[`PSF_BIT_TILE_FLUSH] & ~stall;

    // marker flavour per the flush table
    assign marker_send = wr_flush | notify | vf_inv;
    assign marker_pipe = wr_flush | notify;
    assign completion  = wr_flush | notify;
    assign top_inv     = ro_inv;
    // argument checks on the software side
    assign is_invalid  = (dword == 32'h0000_0000)
                       | bad_rl
                       | dword[`PSF_BIT_SNAP_RESET]
                       | (stall_req & ~stall)
                       | bad_pos
                       | bad_sdi
                       | bad_tile;
    assign need_stall  = stall;
    // single command l1 then tile sequencing
    assign l1_then_tile = dword[`PSF_BIT_TILE_FLUSH] & dword[`PSF_BIT_RT_FLUSH]
                        & dword[`PSF_BIT_DEPTH_FLUSH];
endmodule

// [logic/psf_pkg.sv]
// psf_pkg: types shared by the sync command checker
// assumes: compiled before the modules
package psf_pkg;
    // command sequencing states
    typedef enum logic [4:0] {
        PSF_IDLE  = 5'b0_0001,
        PSF_L1    = 5'b0_0010,
        PSF_TILE  = 5'b0_0100,
        PSF_DRAIN = 5'b0_1000,
        PSF_FULL  = 5'b1_0000
    } psf_state_t;
endpackage

// [logic/psf_tracker.sv]
// psf_tracker: counts sync markers in flight, up to the limit
// assumes: done never arrives with the count at zero
`timescale 1ns/1ps
`include "psf_cfg.svh"
module psf_tracker (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 launch,
    input  wire logic                 done,
    output logic [`PSF_CNT_W-1:0]     count,
    output logic                      full,
    output logic                      empty
);
    logic [`PSF_CNT_W-1:0] next_count;

    // up on launch, down on retire
    always_comb begin
        next_count = count;
        if (launch & ~done & ~full)
            next_count = count + `PSF_CNT_W'(1);
        else if (done & ~launch & ~empty)
            next_count = count - `PSF_CNT_W'(1);
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            count <= '0;
        else
            count <= next_count;
    end

    assign full  = (count == `PSF_MAX_OUT);
    assign empty = (count == '0);
endmodule

// [sim/psf_assertions.sv]
// psf_assertions.sv: port timing checks on the sync command interpreter
// assumes: bound to psf_checker; one clock, reset synchronous active low
`timescale 1ns/1ps
module psf_sva (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        cmd_valid,
    input wire logic [31:0] cmd_dword,
    input wire logic        pos_only,
    input wire logic        tile_mode,
    input wire logic        marker_done,
    input wire logic        l1_done,
    input wire logic        tile_done,
    input wire logic        pipe_idle,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        cmd_ready,
    input wire logic        marker_valid,
    input wire logic        marker_pipe,
    input wire logic        marker_completion,
    input wire logic        top_inv_pulse,
    input wire logic        l1_flush,
    input wire logic        tile_flush,
    input wire logic        dc_flush_obs,
    input wire logic        color_depth_obs,
    input wire logic        post_sync_go,
    input wire logic        irq,
    input wire logic [31:0] reg_rdata
);
    // command take and the flush groups it may carry
    wire                    take  = cmd_valid && cmd_ready;
    wire              [1:0] ps_op = cmd_dword[15:14];
    localparam logic [31:0] WFN   = 32'h0000_1121;
    localparam logic [31:0] NRO   = 32'h0000_0c0c;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // a full tile-mode flush command, then level-1 flush alone
    sequence s_seq_take;
        take && tile_mode && cmd_dword == 32'h1010_1001;
    endsequence
    sequence s_l1_only;
        l1_flush && !tile_flush;
    endsequence
    property p_ready_drop; take |=> !cmd_ready; endproperty
    a_ready_drop: assert property (p_ready_drop)
        else $error("ready held after a take");
    property p_top_cause;
        top_inv_pulse |-> $past(take && |(cmd_dword & NRO));
    endproperty
    a_top_cause: assert property (p_top_cause)
        else $error("top invalidate without cause");
    property p_top_fire;
        take && cmd_dword != 0 && (cmd_dword & ~NRO) == 0 |=> top_inv_pulse;
    endproperty
    a_top_fire: assert property (p_top_fire)
        else $error("top invalidate missing");
    property p_mark_cause;
        marker_pipe |-> marker_valid && marker_completion
            && $past(take && |(cmd_dword & WFN));
    endproperty
    a_mark_cause: assert property (p_mark_cause)
        else $error("pipe marker without flush or notify");
    property p_vf_only;
        take && cmd_dword == 32'h0000_0010 |=> marker_valid && !marker_pipe;
    endproperty
    a_vf_only: assert property (p_vf_only)
        else $error("vertex invalidate marker wrong");
    property p_all_clear;
        take && cmd_dword == 0 |=> !marker_valid && !top_inv_pulse;
    endproperty
    a_all_clear: assert property (p_all_clear)
        else $error("empty command acted");
    property p_reg_load;
        take && cmd_dword[23] && ps_op != 0 |=> !marker_valid;
    endproperty
    a_reg_load: assert property (p_reg_load)
        else $error("register load with post-sync op acted");
    property p_pos_notify;
        take && pos_only && (cmd_dword[8] || cmd_dword[16]) |=> !marker_valid;
    endproperty
    a_pos_notify: assert property (p_pos_notify)
        else $error("position command with notify acted");
    property p_store_idx;
        take && cmd_dword[21] && ps_op == 0 |=> !marker_valid;
    endproperty
    a_store_idx: assert property (p_store_idx)
        else $error("store index without op acted");
    property p_post_after; post_sync_go |-> $past(marker_done); endproperty
    a_post_after: assert property (p_post_after)
        else $error("post-sync before marker done");
    property p_l1_first; s_seq_take |=> s_l1_only; endproperty
    a_l1_first: assert property (p_l1_first)
        else $error("level-1 flush not first");
    property p_cd_obs; color_depth_obs |-> $past(!tile_mode); endproperty
    a_cd_obs: assert property (p_cd_obs)
        else $error("color depth observe in tile mode");
    property p_rd_idle; !reg_rd |=> reg_rdata == 0; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
endmodule

bind psf_checker psf_sva u_sva (
    .clock, .rst_n, .cmd_valid, .cmd_dword, .pos_only, .tile_mode,
    .marker_done, .l1_done, .tile_done, .pipe_idle, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .cmd_ready, .marker_valid, .marker_pipe,
    .marker_completion, .top_inv_pulse, .l1_flush, .tile_flush,
    .dc_flush_obs, .color_depth_obs, .post_sync_go, .irq, .reg_rdata
);

// [sim/psf_pipe_model.sv]
// psf_pipe_model.sv: pipeline and cache stand-in behind the streamer
// assumes: fed by psf_checker outputs on the same clock and reset
`timescale 1ns/1ps
module psf_pipe_model (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic marker_valid,
    input  wire logic l1_flush,
    input  wire logic tile_flush,
    input  wire logic hold_done,
    input  wire logic hold_busy,
    output logic      marker_done,
    output logic      l1_done,
    output logic      tile_done,
    output logic      pipe_idle
);
    int pend, tick, c1, c2;
    // retire markers one every third cycle unless held back
    always_ff @(posedge clock) begin
        tick <= (tick + 1) % 3;
        marker_done <= rst_n && !hold_done && pend > 0 && tick == 0;
        pend <= !rst_n ? 0 : pend + int'(marker_valid) - int'(marker_done);
        c1 <= l1_flush ? c1 + 1 : 0;
        c2 <= tile_flush ? c2 + 1 : 0;
    end
    // caches answer a flush level that stood three cycles
    assign l1_done   = (c1 == 3);
    assign tile_done = (c2 == 3);
    assign pipe_idle = !hold_busy && pend == 0;
endmodule

// [sim/tb.sv]
// tb.sv: self-checking bench for the sync command interpreter
// assumes: psf_checker, psf_pipe_model and the bound checks compiled
`timescale 1ns/1ps
module tb;
    logic        clock, rst_n, cmd_valid, pos_only, tile_mode, reg_wr;
    logic        reg_rd, marker_done, l1_done, tile_done, pipe_idle;
    logic        hold_done, hold_busy, cmd_ready, marker_valid, irq;
    logic        marker_pipe, marker_completion, top_inv_pulse, l1_flush;
    logic        tile_flush, dc_flush_obs, color_depth_obs, post_sync_go;
    logic [3:0]  reg_addr;
    logic [31:0] cmd_dword, reg_wdata, reg_rdata;
    int          n_fail, checks, k;
    logic        ps_seen;
    // directed commands: {pos_only, tile_mode, dword}
    logic [33:0] cases [22] = '{34'h0_0000_0010, 34'h0_0000_0c00,
        34'h0_0000_0c14, 34'h0_0000_0100, 34'h0_0000_1000, 34'h0_0000_0020,
        34'h0_0000_0001, 34'h0_0000_0000, 34'h0_0080_4000, 34'h0_0018_1000,
        34'h0_0001_0000, 34'h0_0000_0200, 34'h0_0004_0000, 34'h0_0020_0000,
        34'h1_1000_1001, 34'h2_0000_0100, 34'h2_0000_9000, 34'h0_0000_9000,
        34'h0_1000_1001, 34'h0_0080_1000,
        34'h1_0000_1001, 34'h1_1010_0000};

    psf_checker dut (.clock, .rst_n, .cmd_valid, .cmd_dword, .pos_only,
        .tile_mode, .marker_done, .l1_done, .tile_done, .pipe_idle, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .cmd_ready, .marker_valid,
        .marker_pipe, .marker_completion, .top_inv_pulse, .l1_flush,
        .tile_flush, .dc_flush_obs, .color_depth_obs, .post_sync_go, .irq,
        .reg_rdata);
    psf_pipe_model u_pipe (.clock, .rst_n, .marker_valid, .l1_flush,
        .tile_flush, .hold_done, .hold_busy, .marker_done, .l1_done,
        .tile_done, .pipe_idle);

    // free-running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
        checks++;
    endtask

    // reference result: {marker, pipe marker, top invalidate,
    // data observe, color depth observe, l1 flush, tile flush}
    function automatic logic [6:0] model(logic [31:0] d, logic p, t);
        logic [1:0] ps;
        logic       bad;
        ps  = d[15:14];
        bad = d == 0 || (d[23] && ps != 0) || d[19]
            || ((d[16] || d[9] || d[18]) && !d[20])
            || (p && (d[16] || d[8] || ps == 2'h2))
            || (d[21] && ps == 0) || (t && d[28] && !d[20]);
        if (bad) return 7'h00;
        return {|(d & 32'h0000_1131), |(d & 32'h0000_1121),
                |(d & 32'h0000_0c0c), !t && d[5], !t && d[28],
                t && (d[12] || d[0]), t && d[28] && !(d[12] && d[0])};
    endfunction

    task automatic send(input logic [31:0] d, input logic p, t);
        logic [6:0] e;
        int         n;
        e = model(d, p, t);
        n = 0;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_dword <= d;
        pos_only  <= p;
        tile_mode <= t;
        do begin
            @(posedge clock);
            n++;
        end while (cmd_ready !== 1'b1 && n < 400);
        cmd_valid <= 1'b0;
        #1;
        if (n >= 400) n_fail++;
        chk("marker", marker_valid, e[6]);
        chk("pipe", marker_pipe, e[5]);
        chk("compl", marker_completion, e[5]);
        chk("top", top_inv_pulse, e[4]);
        chk("dc_obs", dc_flush_obs, e[3]);
        chk("cd_obs", color_depth_obs, e[2]);
        chk("l1_step", l1_flush, e[1]);
        chk("tile_step", tile_flush, e[0]);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, string nm);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata, e);
    endtask

    task automatic conclude;
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial begin
        {cmd_valid, pos_only, tile_mode, reg_wr, reg_rd} = '0;
        {hold_done, hold_busy, rst_n} = '0;
        cmd_dword = '0;
        reg_addr  = '0;
        reg_wdata = '0;
        void'($urandom(7035));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        foreach (cases[i]) send(cases[i][31:0], cases[i][33], cases[i][32]);
        repeat (80) send($urandom & 32'h10b5_df3d, 1'($urandom), 1'($urandom));
        send(32'h1010_1001, 1'b0, 1'b1);
        chk("l1", l1_flush, 1'b1);
        chk("tile", tile_flush, 1'b0);
        send(32'h0010_1000, 1'b0, 1'b0);
        @(posedge clock);
        hold_busy <= 1'b1;
        repeat (8) @(posedge clock);
        chk("drain", cmd_ready, 1'b0);
        hold_busy <= 1'b0;
        // let the drain finish before markers are held back
        k = 0;
        while (cmd_ready !== 1'b1 && k++ < 300) @(posedge clock);
        if (k > 300) n_fail++;
        hold_done <= 1'b1;
        repeat (32) send(32'h0000_1000, 1'b0, 1'b0);
        rd(4'h2, 32'h0000_0020, "count");
        repeat (4) @(posedge clock);
        chk("full", cmd_ready, 1'b0);
        chk("post_go", post_sync_go, 1'b0);
        hold_done <= 1'b0;
        k = 0;
        ps_seen = 1'b0;
        while (pipe_idle !== 1'b1 && k++ < 300) begin
            @(posedge clock);
            ps_seen |= post_sync_go;
        end
        if (k > 300) n_fail++;
        chk("post_go", ps_seen, 1'b1);
        wr(4'h1, 32'h0000_0000);
        wr(4'h0, 32'h0000_0003);
        rd(4'h0, 32'h0000_0000, "status");
        send(32'h0000_0000, 1'b0, 1'b0);
        rd(4'h0, 32'h0000_0001, "status");
        chk("irq", irq, 1'b0);
        wr(4'h1, 32'h0000_0001);
        repeat (2) @(posedge clock);
        #1 chk("irq", irq, 1'b1);
        rd(4'h1, 32'h0000_0001, "mask");
        wr(4'h0, 32'h0000_0001);
        repeat (2) @(posedge clock);
        #1 chk("irq", irq, 1'b0);
        rd(4'hf, 32'h0000_0000, "unmapped");
        conclude();
    end

    // hang guard
    initial begin
        #300000;
        n_fail++;
        conclude();
    end
endmodule
